// [rtl/gpio_consts.vh]
// constants for the six-port general-purpose pin block
`ifndef GPIO_CONSTS_VH
`define GPIO_CONSTS_VH

// register indices; byte address is four times the index
`define GP_IDX_A_DATA 5'h00
`define GP_IDX_A_DIR 5'h01
`define GP_IDX_A_OPT 5'h02
`define GP_IDX_C_DATA 5'h04
`define GP_IDX_C_DIR 5'h05
`define GP_IDX_C_OPT 5'h06
`define GP_IDX_B_DATA 5'h08
`define GP_IDX_B_DIR 5'h09
`define GP_IDX_B_OPT 5'h0A
`define GP_IDX_E_DATA 5'h0C
`define GP_IDX_E_DIR 5'h0D
`define GP_IDX_E_OPT 5'h0E
`define GP_IDX_D_DATA 5'h10
`define GP_IDX_D_DIR 5'h11
`define GP_IDX_D_OPT 5'h12
`define GP_IDX_F_DATA 5'h14
`define GP_IDX_F_DIR 5'h15
`define GP_IDX_F_OPT 5'h16
`define GP_IDX_SENS 5'h18
`define GP_IDX_STAT 5'h19

// sub-register select within a port slot (index bits 1:0)
`define GP_SUB_DATA 2'h0
`define GP_SUB_DIR 2'h1
`define GP_SUB_OPT 2'h2
`define GP_SLOTS 6

// reset values
`define GP_RST_PORT 8'h00
`define GP_RST_SENS 4'h0

// sensitivity register fields
`define GP_SENS_LO 1:0
`define GP_SENS_HI 3:2
`define GP_SENS_W 4

// sensitivity codes
`define GP_SENS_FALL_LOW 2'h0
`define GP_SENS_RISE 2'h1
`define GP_SENS_FALL 2'h2
`define GP_SENS_BOTH 2'h3

// pin members of each interrupt group, slot order A,C,B,E,D,F
`define GP_GRP0_PINS 48'h00000000000F
`define GP_GRP1_PINS 48'h070000000000
`define GP_GRP2_PINS 48'h0000000F0000
`define GP_GRP3_PINS 48'h000000F00000
`define GP_GROUPS 4

`endif

// [rtl/pin_sync.v]
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
   parameter WIDTH = 48
) (
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule // pin_sync

`default_nettype wire

// [rtl/gpio_ports.v]
// six 8-bit bidirectional ports with APB registers and external interrupts
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_consts.vh"

module gpio_ports #(
   // pins with no pull-up and no high-side driver
   parameter [47:0] TOD_MASK = 48'h0000000000C0,
   // pins able to raise an external interrupt
   parameter [47:0] IRQ_MASK = 48'h070000FF000F,
   // interrupt pins that have no pull-up
   parameter [47:0] NOPU_MASK = 48'h040000880008
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   input wire [47:0] pin_in,
   output reg [47:0] pin_out,
   output reg [47:0] pin_oe,
   output reg [47:0] pin_pullup,
   input wire [47:0] alt_out_en,
   input wire [47:0] alt_out_val,
   input wire [47:0] alt_out_od,
   output reg [47:0] alt_in,
   input wire irq_masked,
   input wire [3:0] vec_fetch,
   output wire [3:0] irq_req,
   output wire wakeup
);

   // register hit on an aligned word address
   function hit;
      input [7:0] a;
      input [4:0] i;
      begin
         hit = (a[7:2] == {1'b0, i});
      end
   endfunction

   // event decode for one group from its code and levels
   function grp_event;
      input [1:0] code;
      input lvl;
      input prev;
      begin
         case (code)
            `GP_SENS_FALL_LOW: grp_event = ~lvl;
            `GP_SENS_RISE: grp_event = lvl & ~prev;
            `GP_SENS_FALL: grp_event = ~lvl & prev;
            `GP_SENS_BOTH: grp_event = lvl ^ prev;
            default: grp_event = 1'b0;
         endcase
      end
   endfunction

   reg [47:0] latch;
   reg [47:0] dir;
   reg [47:0] opt;
   reg [`GP_SENS_W-1:0] sens;
   reg [3:0] pending;
   reg [3:0] prev_lvl;
   wire [47:0] pin_s;
   wire wr;
   wire setup;
   wire [4:0] idx;
   wire [47:0] opt_eff;
   wire [47:0] out_mode;
   wire [47:0] push_pull;
   wire [47:0] drive_val;
   wire [47:0] read_data;
   wire [47:0] src_en;
   wire [47:0] grp_pins [0:3];
   wire [3:0] grp_lvl;
   wire [3:0] grp_act;
   wire [3:0] grp_evt;
   wire sens_wr;
   reg [31:0] next_rdata;
   reg next_slverr;
   integer k;

   // pin levels cross into the clock domain before anything reads them
   pin_sync #(
      .WIDTH(48)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .async_in(pin_in),
      .sync_out(pin_s)
   );

   // zero wait states; read data is captured in the setup cycle
   assign pready = 1'b1;
   assign wr = psel & penable & pwrite;
   assign setup = psel & ~penable;
   assign idx = paddr[6:2];

   // data, direction and option registers for every port slot
   genvar s;
   generate
      for (s = 0; s < `GP_SLOTS; s = s + 1) begin : g_port
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               latch[8*s +: 8] <= `GP_RST_PORT;
               dir[8*s +: 8] <= `GP_RST_PORT;
               opt[8*s +: 8] <= `GP_RST_PORT;
            end else if (wr) begin
               // latch updates regardless of direction
               if (hit(paddr, {s[2:0], `GP_SUB_DATA}))
                  latch[8*s +: 8] <= pwdata[7:0];
               if (hit(paddr, {s[2:0], `GP_SUB_DIR}))
                  dir[8*s +: 8] <= pwdata[7:0];
               if (hit(paddr, {s[2:0], `GP_SUB_OPT}))
                  opt[8*s +: 8] <= pwdata[7:0];
            end
         end
      end
   endgenerate

   // true open-drain pins have no option bit at all
   assign opt_eff = opt & ~TOD_MASK;

   // peripheral output claims the pin and forces output mode
   assign out_mode = alt_out_en | dir;

   // peripheral chooses its own output type, option bit otherwise;
   // the choice is made pin by pin so one claim never steals a whole port
   assign push_pull = (alt_out_en & ~alt_out_od & ~TOD_MASK)
                    | (~alt_out_en & opt_eff & dir);

   // driven level comes from the peripheral only on the pins it owns
   assign drive_val = (alt_out_en & alt_out_val) | (~alt_out_en & latch);

   // per-bit read value of the data register
   assign read_data = (dir & latch)
                    | (~dir & alt_out_en & alt_out_val)
                    | (~dir & ~alt_out_en & pin_s);

   // pad controls are registered; they only follow register state and peripheral claims,
   // so stopping the CPU in a low-power mode leaves them as they are
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= 48'h000000000000;
         pin_oe <= 48'h000000000000;
         pin_pullup <= 48'h000000000000;
         alt_in <= 48'h000000000000;
      end else begin
         pin_out <= drive_val;
         // open drain drives only the low level
         pin_oe <= out_mode & (push_pull | ~drive_val);
         // pull-up only on inputs whose pad has one
         pin_pullup <= ~out_mode & opt_eff
                       & ~(IRQ_MASK & NOPU_MASK);
         // a pin with direction 1 hands the latch to the peripheral input
         alt_in <= (dir & latch) | (~dir & pin_s);
      end
   end

   // interrupt input: capable pin, direction 0, option 1, not claimed
   assign src_en = IRQ_MASK & ~dir & opt_eff & ~alt_out_en;

   assign grp_pins[0] = `GP_GRP0_PINS;
   assign grp_pins[1] = `GP_GRP1_PINS;
   assign grp_pins[2] = `GP_GRP2_PINS;
   assign grp_pins[3] = `GP_GRP3_PINS;

   // sensitivity may change only while the CPU masks interrupts
   assign sens_wr = wr & hit(paddr, `GP_IDX_SENS) & irq_masked;

   // per group: AND of enabled pins, edge/level detect, pending latch
   genvar g;
   generate
      for (g = 0; g < `GP_GROUPS; g = g + 1) begin : g_grp
         // disabled pins read as high so they never mask the others
         assign grp_lvl[g] = &(pin_s | ~(src_en & grp_pins[g]));
         assign grp_act[g] = |(src_en & grp_pins[g]);
         assign grp_evt[g] = grp_act[g] & grp_event(
            (g < 2) ? sens[`GP_SENS_LO] : sens[`GP_SENS_HI],
            grp_lvl[g], prev_lvl[g]);

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               prev_lvl[g] <= 1'b1;
               pending[g] <= 1'b0;
            end else begin
               prev_lvl[g] <= grp_lvl[g];
               // a new event beats the clear in the same cycle
               if (grp_evt[g])
                  pending[g] <= 1'b1;
               else if (vec_fetch[g] | sens_wr)
                  pending[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // sensitivity register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sens <= `GP_RST_SENS;
      else if (sens_wr)
         sens <= pwdata[`GP_SENS_W-1:0];
   end

   // request reaches the CPU only while its mask bit is clear
   assign irq_req = pending & {4{~irq_masked}};

   // pending requests wake the core from wait or halt
   assign wakeup = |pending;

   // read decode, unmapped addresses answer with an error
   always @* begin
      next_rdata = 32'h00000000;
      next_slverr = 1'b1;
      if (!paddr[7]) begin
         for (k = 0; k < `GP_SLOTS; k = k + 1) begin
            if (idx[4:2] == k[2:0]) begin
               case (idx[1:0])
                  `GP_SUB_DATA: begin
                     next_rdata[7:0] = read_data[8*k +: 8];
                     next_slverr = 1'b0;
                  end
                  `GP_SUB_DIR: begin
                     next_rdata[7:0] = dir[8*k +: 8];
                     next_slverr = 1'b0;
                  end
                  `GP_SUB_OPT: begin
                     next_rdata[7:0] = opt_eff[8*k +: 8];
                     next_slverr = 1'b0;
                  end
                  default: begin
                     next_rdata = 32'h00000000;
                     next_slverr = 1'b1;
                  end
               endcase
            end
         end
         if (idx == `GP_IDX_SENS) begin
            next_rdata[`GP_SENS_W-1:0] = sens;
            next_slverr = 1'b0;
         end
         if (idx == `GP_IDX_STAT) begin
            // pending latch is visible for debug only, never writable
            next_rdata[7:0] = {grp_lvl, pending};
            next_slverr = 1'b0;
         end
      end
   end

   // capture answer at setup so it is stable through the access phase;
   // the trade is read data one cycle older than the access edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h00000000 : next_rdata;
         pslverr <= next_slverr;
      end
   end

endmodule // gpio_ports

`default_nettype wire

// [dv/gpio_ports_asserts.sv]
// assertion checker for the six-port pin block
`timescale 1ns/100ps
`default_nettype none
module gpio_ports_asserts #(
   parameter [47:0] TOD_MASK = 48'h0000000000C0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [47:0] pin_out,
   input wire logic [47:0] pin_oe,
   input wire logic [47:0] pin_pullup,
   input wire logic [47:0] alt_out_en,
   input wire logic [47:0] alt_out_val,
   input wire logic [47:0] alt_out_od,
   input wire logic irq_masked,
   input wire logic [3:0] vec_fetch,
   input wire logic [3:0] irq_req,
   input wire logic wakeup
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // peripheral claims split by the output type the peripheral asks for
   // open-drain-only pads have no high side, so they never count as push-pull
   wire [47:0] pp = alt_out_en & ~alt_out_od & ~TOD_MASK;
   wire [47:0] od = alt_out_en & alt_out_od;
   // sensitivity writes only land while the cpu mask is set
   sequence s_sens_wr;
      psel && penable && pwrite && paddr == 8'h60 && irq_masked;
   endsequence
   property p_alt_pp;
      1 |=> (pin_oe & $past(pp)) == $past(pp) && (pin_out & $past(pp)) == ($past(alt_out_val) & $past(pp));
   endproperty
   a_alt_pp: assert property (p_alt_pp) else $error("claimed push-pull pin not driven");
   property p_alt_od;
      1 |=> (pin_oe & $past(od)) == (~$past(alt_out_val) & $past(od));
   endproperty
   a_alt_od: assert property (p_alt_od) else $error("claimed open-drain pin drive wrong");
   property p_nopull; (pin_oe & pin_pullup) == 48'h0; endproperty
   a_nopull: assert property (p_nopull) else $error("pull-up on a driven pin");
   property p_tod;
      (pin_oe & pin_out & TOD_MASK) == 48'h0 && (pin_pullup & TOD_MASK) == 48'h0;
   endproperty
   a_tod: assert property (p_tod) else $error("open-drain-only pin pulled or driven high");
   property p_mask; irq_masked |-> irq_req == 4'h0; endproperty
   a_mask: assert property (p_mask) else $error("request while cpu mask set");
   property p_wake; irq_req != 4'h0 |-> wakeup; endproperty
   a_wake: assert property (p_wake) else $error("request without wakeup");
   property p_clr;
      $fell(wakeup) |-> $past(vec_fetch) != 4'h0
         || $past(psel && penable && pwrite && paddr == 8'h60 && irq_masked);
   endproperty
   a_clr: assert property (p_clr) else $error("pending dropped without a cause");
   property p_sclr; s_sens_wr |=> !wakeup; endproperty
   a_sclr: assert property (p_sclr) else $error("sensitivity write left pending");
   property p_rst; $rose(presetn) |-> pin_oe == 48'h0 && pin_pullup == 48'h0; endproperty
   a_rst: assert property (p_rst) else $error("pads active out of reset");
endmodule // gpio_ports_asserts
bind gpio_ports gpio_ports_asserts #(.TOD_MASK(TOD_MASK)) u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pin_out, .pin_oe, .pin_pullup, .alt_out_en, .alt_out_val,
   .alt_out_od, .irq_masked, .vec_fetch, .irq_req, .wakeup);
`default_nettype wire

// [dv/pin_partner.sv]
// outside circuitry seen on the 48 port pins
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
   input wire logic clk,
   input wire logic [47:0] pin_out,
   input wire logic [47:0] pin_oe,
   input wire logic [47:0] pin_pullup,
   input wire logic [47:0] ext_en,
   input wire logic [47:0] ext_val,
   output wire logic [47:0] pin_in
);
   logic [47:0] drift = 48'h0;
   // a floating pin wanders so a stale level never passes as valid
   always @(posedge clk) drift <= ~drift;
   // pad drive first, then the outside driver, then pull-up or drift
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pin_pullup | drift));
endmodule // pin_partner
`default_nettype wire

// [dv/gpio_ports_tb.sv]
// self-checking bench for the six-port pin block
`timescale 1ns/100ps
`default_nettype none
module gpio_ports_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_masked, wakeup, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [47:0] pin_in, pin_out, pin_oe, pin_pullup, alt_in, ext_en, ext_val;
   logic [47:0] alt_out_en, alt_out_val, alt_out_od;
   logic [3:0] vec_fetch, irq_req;
   int bad_count = 0;
   int total_checks = 0;
   int c;
   gpio_ports u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pullup, .alt_out_en, .alt_out_val,
      .alt_out_od, .alt_in, .irq_masked, .vec_fetch, .irq_req, .wakeup);
   pin_partner u_pins (.clk(pclk), .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val,
      .pin_in);
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // setup then access, held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // pin changes pass two sync flops plus a register stage
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      tick(5000);
      bad_count++;
      report_and_stop;
   end
   initial begin
      {psel, penable, pwrite, presetn, paddr, pwdata, vec_fetch} = '0;
      {alt_out_en, alt_out_val, alt_out_od, ext_val} = '0;
      ext_en = '1;
      irq_masked = 1'b1;
      tick(4);
      presetn <= 1'b1;
      for (c = 0; c < 6; c++) begin
         rdc(8'(c * 16), 32'h0);
         rdc(8'(c * 16 + 4), 32'h0);
      end
      apb(1'b0, 8'h0C, 32'h0);
      chk({31'h0, er}, 32'h1);
      wr(8'h10, 8'hA5);
      ext_val <= 48'h3C00;
      tick(6);
      rdc(8'h10, 32'h3C);
      chk(32'(alt_in[15:8]), 32'h3C);
      wr(8'h14, 8'hFF);
      tick(2);
      rdc(8'h10, 32'hA5);
      chk(32'(alt_in[15:8]), 32'hA5);
      wr(8'h40, 8'h0F);
      // walk all four direction and option codes on one port
      for (c = 0; c < 4; c++) begin
         wr(8'h44, c[1] ? 8'hFF : 8'h00);
         wr(8'h48, c[0] ? 8'hFF : 8'h00);
         tick(2);
         chk(32'(pin_out[39:32]), 32'h0F);
         chk(32'(pin_oe[39:32]), c == 3 ? 32'hFF : c == 2 ? 32'hF0 : 32'h0);
         chk(32'(pin_pullup[39:32]), c == 1 ? 32'hFF : 32'h0);
      end
      wr(8'h00, 8'h40);
      wr(8'h04, 8'hC0);
      wr(8'h08, 8'hC0);
      tick(2);
      chk(32'(pin_oe[7:6]), 32'h2);
      rdc(8'h08, 32'h0);
      alt_out_en <= 48'h0100_0000;
      alt_out_val <= 48'h0100_0000;
      tick(2);
      chk(32'(pin_oe[31:24]), 32'h1);
      chk(32'(pin_out[31:24]), 32'h01);
      // a claim on one pin leaves the other ports on their own programming
      chk(32'(pin_out[15:8]), 32'hA5);
      chk(32'(pin_oe[15:8]), 32'h5A);
      rdc(8'h30, 32'h1);
      alt_out_od <= 48'h0100_0000;
      tick(2);
      chk(32'(pin_oe[31:24]), 32'h0);
      alt_out_en <= 48'h0;
      ext_val <= 48'h00FF_0000;
      wr(8'h28, 8'h0F);
      tick(2);
      chk(32'(pin_pullup[23:16]), 32'h07);
      // each sensitivity code against one low pulse on an enabled pin
      for (c = 0; c < 4; c++) begin
         irq_masked <= 1'b1;
         wr(8'h60, 8'(c << 2));
         rdc(8'h60, 32'(c << 2));
         tick(6);
         irq_masked <= 1'b0;
         ext_val[16] <= 1'b0;
         tick(6);
         chk(32'(irq_req[2]), c == 1 ? 32'h0 : 32'h1);
         ext_val[16] <= 1'b1;
         tick(6);
         chk(32'(irq_req[2]), 32'h1);
         chk(32'(wakeup), 32'h1);
         vec_fetch <= 4'h4;
         tick(1);
         vec_fetch <= 4'h0;
         tick(2);
         chk(32'(irq_req[2]), 32'h0);
      end
      // one enabled pin held low hides the others of its group
      ext_val[17] <= 1'b0;
      tick(6);
      chk(32'(irq_req[2]), 32'h1);
      vec_fetch <= 4'h4;
      tick(1);
      vec_fetch <= 4'h0;
      ext_val[16] <= 1'b0;
      tick(6);
      ext_val[16] <= 1'b1;
      tick(6);
      chk(32'(irq_req[2]), 32'h0);
      rdc(8'h64, 32'hB0);
      // sensitivity is locked while the cpu takes interrupts
      wr(8'h60, 8'h00);
      rdc(8'h60, 32'h0C);
      // a rising group level sets pending; a masked sensitivity write drops it
      ext_val[17] <= 1'b1;
      tick(6);
      chk(32'(wakeup), 32'h1);
      irq_masked <= 1'b1;
      wr(8'h60, 8'h0C);
      tick(1);
      chk(32'(wakeup), 32'h0);
      report_and_stop;
   end
endmodule // gpio_ports_tb
`default_nettype wire
